// >>> include/sfpe_pkg.sv
/*
  Constants for the serial flash program/erase sequencer: opcodes,
  status bit positions, page size and timing counts.
  Assumes a 50 MHz system clock.
*/
`default_nettype none
package sfpe_pkg;
  // ==========================================
  // Opcodes
  localparam logic [7:0] OP_WRITE_ENABLE_CMD = 8'h06;
  localparam logic [7:0] OP_PP = 8'h02;
  localparam logic [7:0] OP_PP4 = 8'h12;
  localparam logic [7:0] OP_QPP = 8'h32;
  localparam logic [7:0] OP_QPP_ALT = 8'h38;
  localparam logic [7:0] OP_QPP4 = 8'h34;
  localparam logic [7:0] OP_SUSP = 8'h85;
  localparam logic [7:0] OP_RESUME = 8'h8A;
  localparam logic [7:0] OP_SE = 8'hD8;
  localparam logic [7:0] OP_SE4 = 8'hDC;
  localparam logic [7:0] OP_BE = 8'h60;
  localparam logic [7:0] OP_BE_ALT = 8'hC7;
  // ==========================================
  // Status fields
  localparam int SR1_PROG = 0;
  localparam int SR1_WEL = 1;
  localparam int SR1_BP0 = 2;
  localparam int SR1_BP1 = 3;
  localparam int SR1_BP2 = 4;
  localparam int SR1_EERR = 5;
  localparam int SR1_PERR = 6;
  localparam int SR1_SPARE = 7;
  localparam int SR2_PSUS = 0;
  // ==========================================
  // Geometry and timing
  localparam int PAGE_BYTES = 512;
  localparam int PAGE_LOG2 = 9;
  localparam int MCLK_MHZ = 50;
  localparam int PROG_BYTE_NS = 200;
  localparam int BYTE_CYC = (PROG_BYTE_NS * MCLK_MHZ + 999) / 1000;
  localparam int PSL_US = 45;
  localparam int PSL_CYC = PSL_US * MCLK_MHZ;
  localparam int ERASE_SECT_US = 4000;
  localparam int ERASE_CYC = ERASE_SECT_US * MCLK_MHZ;
  // ==========================================
  // Opcode classes
  function automatic logic is_pp(input logic [7:0] op);
    return op == OP_PP || op == OP_PP4;
  endfunction
  function automatic logic is_qpp(input logic [7:0] op);
    return op == OP_QPP || op == OP_QPP_ALT || op == OP_QPP4;
  endfunction
  function automatic logic [5:0] addr_bits(input logic [7:0] op,
                                          input logic ext);
    if (op == OP_PP4 || op == OP_QPP4 || op == OP_SE4 || ext)
      return 6'd32;
    return 6'd24;
  endfunction
endpackage
`default_nettype wire

// >>> design/sfpe_core.sv
/*
  Program/erase command sequencer of a serial NOR flash. Link side
  shifts opcode, address and page data on link_sck; system side decodes
  the finished frame and runs program, suspend/resume and erase.
  Assumes arr_rdata follows arr_addr in the same cycle, arr_fail is
  valid while arr_write is high, sector_lock follows arr_addr, and
  quad_enable / extended_address_setting change only between frames.
*/
// Behaviour
// [RULE1] Write enable needed before program or erase
// [RULE2] 02h takes 3/4-byte address, 12h four
// [RULE3] Host sends one byte to one page
// [RULE4] Data past page end wraps to page start
// [RULE5] Short single program touches only sent bytes
// [RULE6] Programming only clears bits
// [RULE7] Progress flag while programming, error on failure
// [RULE8] Quad program needs quad enable and latch
// [RULE9] 32h/38h follow setting, 34h four bytes
// [RULE10] Quad data four bits per clock
// [RULE11] Quad program fills unloaded bytes with ones
// [RULE12] Suspend only while programming, then status only
// [RULE13] Suspend status bit shows suspended or done
// [RULE14] Suspend completes within suspend latency
// [RULE15] Resume only when suspended, sets progress
// [RULE16] Host leaves time between resume and suspend
// [RULE17] Sector erase address length, sector to ones
// [RULE18] Erase only if frame ends after address
// [RULE19] Progress flag set while erasing
// [RULE20] Protected sector erase sets erase error
// [RULE21] Bulk erase only if frame ends after opcode
// [RULE22] Bulk erase needs zero protect, skips locked
// [RULE23] Latch cleared at end or rejection
`default_nettype none
module sfpe_core #(
  parameter int ADDR_W = 26,
  parameter int SECT_LOG2 = 18,
  parameter int ERASE_CYC = sfpe_pkg::ERASE_CYC
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic link_sck,
  input wire logic cs_b,
  input wire logic [3:0] io_in,
  input wire logic quad_enable,
  input wire logic extended_address_setting,
  input wire logic block_protect_bit2,
  input wire logic block_protect_bit1,
  input wire logic block_protect_bit0,
  input wire logic sector_lock,
  input wire logic err_clear,
  output logic [7:0] status_register_one,
  output logic [7:0] status_register_two,
  output logic [31:0] arr_addr,
  input wire logic [7:0] arr_rdata,
  output logic [7:0] arr_wdata,
  output logic arr_write,
  input wire logic arr_fail,
  output logic arr_erase
);
  localparam int SW = ADDR_W - SECT_LOG2;
  localparam int PSL_A = sfpe_pkg::PSL_CYC;
  localparam int BYTE_A = sfpe_pkg::BYTE_CYC;
  // Worst case from suspend request to byte boundary
  localparam int SUS_LIM = BYTE_A + 4;

  initial
  begin
    if (SW < 1 || ADDR_W > 32 || ERASE_CYC < 1)
      $error("sfpe_core: bad geometry or erase count");
    if (BYTE_A + 3 > PSL_A)
      $error("sfpe_core: byte time exceeds suspend latency");
  end

  typedef enum logic [2:0] {
    S_IDLE, S_ECHK, S_ERS, S_ENX, S_PRD, S_PWR, S_PWT, S_SUSP
  } sfpe_state_type;

  // ==========================================
  // Link domain: frame capture on link_sck
  logic first;
  logic [13:0] nedge;
  logic [7:0] op;
  logic [31:0] addr;
  logic [7:0] sh;
  logic [9:0] nbytes;
  logic [8:0] wcnt;
  logic qe_m, qe_s, ext_m, ext_s, busy_m, busy_s;
  logic [7:0] pbuf [sfpe_pkg::PAGE_BYTES];
  logic buf_lock;
  wire frame_rst_b = rst_b & ~cs_b;
  wire [13:0] idx = first ? 14'h0000 : nedge;
  wire [13:0] hdr_s = 14'(8 + sfpe_pkg::addr_bits(op, ext_s));
  wire [13:0] didx = idx - hdr_s;
  wire in_addr = idx >= 14'h0008 && idx < hdr_s;
  wire in_data = idx >= hdr_s;
  wire quad_s = sfpe_pkg::is_qpp(op) & qe_s;
  wire prog_s = sfpe_pkg::is_pp(op) | quad_s;
  wire byte_done = in_data & (quad_s ? didx[0] : didx[2:0] == 3'h7);
  wire [7:0] next_sh = quad_s ? {sh[3:0], io_in} : {sh[6:0], io_in[0]};
  wire [8:0] widx = addr[8:0] + wcnt;

  always_ff @(posedge link_sck or negedge frame_rst_b)
    if (!frame_rst_b)
      first <= 1'b1;
    else
      first <= 1'b0;

  always_ff @(posedge link_sck or negedge rst_b)
    if (!rst_b)
    begin
      {qe_m, qe_s, ext_m, ext_s, busy_m, busy_s} <= 6'h00;
    end
    else
    begin
      {qe_m, qe_s} <= {quad_enable, qe_m};
      {ext_m, ext_s} <= {extended_address_setting, ext_m};
      {busy_m, busy_s} <= {buf_lock, busy_m};
    end

  always_ff @(posedge link_sck or negedge rst_b)
    if (!rst_b)
    begin
      nedge <= 14'h0000;
      op <= 8'h00;
      addr <= 32'h0000_0000;
      sh <= 8'h00;
      nbytes <= 10'h000;
      wcnt <= 9'h000;
    end
    else
    begin
      if (idx != 14'h3FFF)
        nedge <= idx + 14'h0001;
      if (idx < 14'h0008)
        op <= {op[6:0], io_in[0]};
      if (idx == 14'h0000)
      begin
        addr <= 32'h0000_0000;
        nbytes <= 10'h000;
        wcnt <= 9'h000;
      end
      if (in_addr)
        addr <= {addr[30:0], io_in[0]}; // RULE2 RULE9 RULE17
      if (in_data)
        sh <= next_sh; // RULE10
      if (byte_done)
      begin
        wcnt <= wcnt + 9'h001; // RULE4
        if (nbytes != 10'(sfpe_pkg::PAGE_BYTES))
          nbytes <= nbytes + 10'h001; // RULE3
      end
    end

  // Page buffer written only while the system side is idle
  always_ff @(posedge link_sck)
    if (byte_done && prog_s && !busy_s)
      pbuf[widx] <= next_sh; // RULE4

  // ==========================================
  // System domain: frame end and decode
  logic cs_m, cs_s, cs_d;
  always_ff @(posedge mclk or negedge rst_b)
    if (!rst_b)
      {cs_m, cs_s, cs_d} <= 3'b111;
    else if (ce)
      {cs_m, cs_s, cs_d} <= {cs_b, cs_m, cs_s};

  sfpe_state_type state;
  logic progress, write_enable_latch, perr, eerr, psus, sus_req, be_mode;
  logic [22:0] pbase;
  logic [8:0] poff;
  logic [9:0] pn, ptot, pi;
  logic [7:0] pdat;
  logic [31:0] tmr;

  wire fr_end = cs_s & ~cs_d;
  wire [2:0] bp = {block_protect_bit2, block_protect_bit1,
                   block_protect_bit0};
  wire [13:0] hdr = 14'(8 + sfpe_pkg::addr_bits(op,
                   extended_address_setting));
  wire one_byte = nedge == 14'h0008;
  wire write_enable_cmd_ok = op == sfpe_pkg::OP_WRITE_ENABLE_CMD && one_byte;
  wire qpp_cmd = sfpe_pkg::is_qpp(op);
  wire prog_cmd = sfpe_pkg::is_pp(op) | qpp_cmd;
  wire prog_ok = nbytes != 10'h000 && (!qpp_cmd || quad_enable); // RULE8
  wire se_cmd = op == sfpe_pkg::OP_SE || op == sfpe_pkg::OP_SE4;
  wire se_ok = nedge == hdr; // RULE18
  wire be_cmd = op == sfpe_pkg::OP_BE || op == sfpe_pkg::OP_BE_ALT;
  wire susp_ok = op == sfpe_pkg::OP_SUSP && one_byte;
  wire res_ok = op == sfpe_pkg::OP_RESUME && one_byte;
  wire prog_run = state == S_PRD || state == S_PWR || state == S_PWT;
  wire [8:0] pofs = poff + pi[8:0]; // RULE4
  wire [SW-1:0] sidx = arr_addr[ADDR_W-1:SECT_LOG2];
  wire last_sect = &sidx;
  wire [2:0] bp_sh = 3'h7 - bp;
  wire [SW:0] bp_lim = (SW+1)'(1 << SW) >> bp_sh;
  wire bp_hit = bp != 3'h0 && {1'b0, ~sidx} < bp_lim;
  wire prot_hit = bp_hit | sector_lock;
  wire perr_set = state == S_PWT && arr_write && arr_fail; // RULE7
  wire eerr_set = state == S_ECHK && !be_mode && prot_hit; // RULE20
  wire last_byte = pi + 10'h001 == ptot;
  wire [31:0] sect_next = {arr_addr[31:SECT_LOG2] + 1'b1,
                           SECT_LOG2'(0)};

  always_ff @(posedge mclk or negedge rst_b)
    if (!rst_b)
    begin
      perr <= 1'b0;
      eerr <= 1'b0;
      buf_lock <= 1'b0;
    end
    else if (ce)
    begin
      perr <= perr_set | (perr & ~err_clear);
      eerr <= eerr_set | (eerr & ~err_clear);
      buf_lock <= state != S_IDLE;
    end

  // ==========================================
  // Sequencer
  always_ff @(posedge mclk or negedge rst_b)
    if (!rst_b)
    begin
      state <= S_IDLE;
      progress <= 1'b0;
      write_enable_latch <= 1'b0;
      psus <= 1'b0;
      sus_req <= 1'b0;
      be_mode <= 1'b0;
      pbase <= 23'h00_0000;
      poff <= 9'h000;
      pn <= 10'h000;
      ptot <= 10'h000;
      pi <= 10'h000;
      pdat <= 8'h00;
      tmr <= 32'h0000_0000;
      arr_addr <= 32'h0000_0000;
      arr_wdata <= 8'h00;
      arr_write <= 1'b0;
      arr_erase <= 1'b0;
    end
    else if (ce)
    begin
      arr_write <= 1'b0;
      arr_erase <= 1'b0;
      if (fr_end && susp_ok && prog_run)
        sus_req <= 1'b1; // RULE12
      case (state)
        S_IDLE:
          if (fr_end)
          begin
            if (write_enable_cmd_ok)
              write_enable_latch <= 1'b1; // RULE1
            else if (prog_cmd && write_enable_latch)
            begin
              if (prog_ok)
              begin
                pbase <= addr[31:9];
                poff <= addr[8:0];
                pn <= nbytes;
                ptot <= qpp_cmd ? 10'(sfpe_pkg::PAGE_BYTES) : nbytes;
                pi <= 10'h000;
                progress <= 1'b1; // RULE7
                state <= S_PRD;
              end
              else
                write_enable_latch <= 1'b0; // RULE23
            end
            else if (se_cmd && write_enable_latch)
            begin
              if (se_ok)
              begin
                arr_addr <= addr;
                be_mode <= 1'b0;
                progress <= 1'b1;
                state <= S_ECHK;
              end
              else
                write_enable_latch <= 1'b0; // RULE18
            end
            else if (be_cmd && write_enable_latch)
            begin
              if (one_byte && bp == 3'h0) // RULE21 RULE22
              begin
                arr_addr <= 32'h0000_0000;
                be_mode <= 1'b1;
                progress <= 1'b1;
                state <= S_ECHK;
              end
              else
                write_enable_latch <= 1'b0; // RULE23
            end
          end
        S_ECHK:
          if (!prot_hit)
          begin
            tmr <= 32'h0000_0000;
            state <= S_ERS;
          end
          else if (!be_mode || last_sect)
          begin
            progress <= 1'b0; // RULE20
            write_enable_latch <= 1'b0;
            state <= S_IDLE;
          end
          else
            arr_addr <= sect_next; // RULE22
        S_ERS:
          if (tmr == 32'(ERASE_CYC - 1))
          begin
            arr_erase <= 1'b1; // RULE17
            state <= S_ENX;
          end
          else
            tmr <= tmr + 32'h0000_0001;
        S_ENX:
          if (be_mode && !last_sect)
          begin
            arr_addr <= sect_next;
            state <= S_ECHK;
          end
          else
          begin
            progress <= 1'b0; // RULE19
            write_enable_latch <= 1'b0; // RULE23
            state <= S_IDLE;
          end
        S_PRD:
        begin
          arr_addr <= {pbase, pofs};
          pdat <= pi < pn ? pbuf[pofs] : 8'hFF; // RULE5 RULE11
          state <= S_PWR;
        end
        S_PWR:
        begin
          arr_wdata <= arr_rdata & pdat; // RULE6
          arr_write <= 1'b1;
          tmr <= 32'h0000_0000;
          state <= S_PWT;
        end
        S_PWT:
          if (perr_set || (tmr == 32'(BYTE_A - 1) && last_byte))
          begin
            progress <= 1'b0; // RULE7
            write_enable_latch <= 1'b0; // RULE23
            sus_req <= 1'b0; // RULE13
            state <= S_IDLE;
          end
          else if (tmr == 32'(BYTE_A - 1))
          begin
            pi <= pi + 10'h001;
            if (sus_req)
            begin
              progress <= 1'b0; // RULE14
              psus <= 1'b1; // RULE13
              sus_req <= 1'b0;
              state <= S_SUSP;
            end
            else
              state <= S_PRD;
          end
          else
            tmr <= tmr + 32'h0000_0001;
        S_SUSP:
          if (fr_end && res_ok)
          begin
            progress <= 1'b1; // RULE15
            psus <= 1'b0;
            state <= S_PRD;
          end
        default:
          state <= S_IDLE;
      endcase
    end

  // ==========================================
  // Status outputs
  assign status_register_one[sfpe_pkg::SR1_PROG] = progress;
  assign status_register_one[sfpe_pkg::SR1_WEL] = write_enable_latch;
  assign status_register_one[sfpe_pkg::SR1_BP0] = block_protect_bit0;
  assign status_register_one[sfpe_pkg::SR1_BP1] = block_protect_bit1;
  assign status_register_one[sfpe_pkg::SR1_BP2] = block_protect_bit2;
  assign status_register_one[sfpe_pkg::SR1_EERR] = eerr;
  assign status_register_one[sfpe_pkg::SR1_PERR] = perr;
  assign status_register_one[sfpe_pkg::SR1_SPARE] = 1'b0;
  assign status_register_two = {7'h00, psus};

  // ==========================================
  // Checks
  sequence s_idle_end;
    state == S_IDLE && fr_end;
  endsequence
  sequence s_sus_ask;
    fr_end && susp_ok && prog_run && !sus_req;
  endsequence
  sequence s_sus_done;
    state == S_PWT && sus_req && tmr == 32'(BYTE_A - 1) && !last_byte
      && !perr_set;
  endsequence

  a_wel_on_write_enable_cmd: assert property (@(posedge mclk) // RULE1
    disable iff (!rst_b || !ce) s_idle_end ##0 write_enable_cmd_ok |=> write_enable_latch)
    else $error("latch not set after write enable");
  a_start_needs_wel: assert property (@(posedge mclk) // RULE1
    disable iff (!rst_b || !ce)
    state == S_IDLE ##1 state == S_PRD |-> $past(write_enable_latch))
    else $error("program started without latch");
  a_only_clears: assert property (@(posedge mclk) // RULE6
    disable iff (!rst_b || !ce)
    arr_write |-> (arr_wdata & ~$past(arr_rdata)) == 8'h00)
    else $error("program would set a bit");
  a_page_wrap: assert property (@(posedge mclk) // RULE4
    disable iff (!rst_b || !ce) arr_write |-> arr_addr[31:9] == pbase)
    else $error("write left the page");
  a_prog_flag: assert property (@(posedge mclk) // RULE7
    disable iff (!rst_b || !ce) prog_run |-> status_register_one[0])
    else $error("progress flag low while programming");
  a_perr_set: assert property (@(posedge mclk) // RULE7
    disable iff (!rst_b || !ce)
    perr_set |=> status_register_one[6] && !status_register_one[0])
    else $error("program error not flagged");
  a_sus_latency: assert property (@(posedge mclk) // RULE14
    disable iff (!rst_b || !ce)
    s_sus_ask |-> ##[1:SUS_LIM] (state == S_SUSP || state == S_IDLE))
    else $error("suspend not finished in time");
  a_sus_status: assert property (@(posedge mclk) // RULE13
    disable iff (!rst_b || !ce)
    s_sus_done |=> status_register_two[0] && !status_register_one[0])
    else $error("suspend status wrong");
  a_resume: assert property (@(posedge mclk) // RULE15
    disable iff (!rst_b || !ce)
    state == S_SUSP && fr_end && res_ok |=> progress ##1 prog_run)
    else $error("resume did not restart programming");
  a_erase_flag: assert property (@(posedge mclk) // RULE19
    disable iff (!rst_b || !ce)
    (state == S_ERS || state == S_ECHK) |-> status_register_one[0])
    else $error("progress flag low while erasing");
  a_se_protect: assert property (@(posedge mclk) // RULE20
    disable iff (!rst_b || !ce)
    eerr_set |=> eerr && state == S_IDLE && !arr_erase)
    else $error("protected sector erase not refused");
  a_be_dropped: assert property (@(posedge mclk) // RULE22
    disable iff (!rst_b || !ce)
    s_idle_end ##0 be_cmd && write_enable_latch && bp != 3'h0
      |=> state == S_IDLE && !write_enable_latch && $stable(eerr))
    else $error("bulk erase not dropped");
endmodule
`default_nettype wire

// >>> sim/sfpe_host.sv
/*
  Host link model: frames commands on cs_b, link_sck and io_in.
  Assumes a 12 ns link clock that stands still between frames.
*/
`default_nettype none
module sfpe_host (
  output var logic link_sck,
  output var logic cs_b,
  output var logic [3:0] io_in
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    link_sck = 1'b0;
    cs_b = 1'b1;
    io_in = 4'h0;
  end
  // ==========================================
  // One link clock, lines set before the rise
  task automatic shift(input logic [3:0] v);
    io_in = v;
    #6 link_sck = 1'b1;
    #6 link_sck = 1'b0;
  endtask
  // ==========================================
  // Opcode, address, data, then optional stray bits
  task automatic frame(input logic [7:0] op, input int abits,
    input logic [31:0] addr, input logic [7:0] d[$], input bit quad,
    input int xbits);
    int i;
    int j;
    cs_b = 1'b0;
    for (i = 7; i >= 0; i--)
      shift({~io_in[3:1], op[i]});
    for (i = abits - 1; i >= 0; i--)
      shift({~io_in[3:1], addr[i]});
    for (j = 0; j < d.size(); j++)
      if (quad)
      begin
        shift(d[j][7:4]);
        shift(d[j][3:0]);
      end
      else
        for (i = 7; i >= 0; i--)
          shift({~io_in[3:1], d[j][i]});
    for (i = 0; i < xbits; i++)
      shift(~io_in);
    #6 cs_b = 1'b1;
    io_in = ~io_in;
    #100;
  endtask
endmodule
`default_nettype wire

// >>> sim/tb.sv
/*
  Self-checking bench for sfpe_core: host link model plus array model.
  Assumes the package, the core and sfpe_host are compiled first.
*/
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int AW = 12;
  logic mclk, rst_b, link_sck, cs_b, quad_enable, ext, sector_lock;
  logic bp2, bp1, bp0, err_clear, arr_write, arr_fail, arr_erase;
  logic [3:0] io_in;
  logic [7:0] sr1, sr2, arr_wdata, arr_rdata;
  logic [31:0] arr_addr;
  logic [7:0] mem [0:4095];
  logic [7:0] exp_mem [0:4095];
  logic [7:0] none_q[$];
  logic [7:0] qops [0:2] = '{8'h32, 8'h38, 8'h34};
  int fail_count, samples_checked, erase_seen, seed, i, k;
  assign arr_rdata = mem[arr_addr[AW-1:0]];
  always #10 mclk = ~mclk;
  always @(posedge mclk)
    if (arr_write && !arr_fail)
      mem[arr_addr[AW-1:0]] <= arr_wdata;
  always @(posedge mclk)
    if (arr_erase)
      erase_seen++;
  sfpe_core #(.ADDR_W(AW), .SECT_LOG2(9), .ERASE_CYC(20)) u_sfpe_core (
    .mclk(mclk), .rst_b(rst_b), .ce(1'b1), .link_sck(link_sck),
    .cs_b(cs_b), .io_in(io_in), .quad_enable(quad_enable),
    .extended_address_setting(ext), .block_protect_bit2(bp2),
    .block_protect_bit1(bp1), .block_protect_bit0(bp0),
    .sector_lock(sector_lock), .err_clear(err_clear),
    .status_register_one(sr1), .status_register_two(sr2),
    .arr_addr(arr_addr), .arr_rdata(arr_rdata), .arr_wdata(arr_wdata),
    .arr_write(arr_write), .arr_fail(arr_fail), .arr_erase(arr_erase));
  sfpe_host u_sfpe_host (.link_sck(link_sck), .cs_b(cs_b), .io_in(io_in));
  // ==========================================
  // Reporting
  task conclude;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task check_bit(input string name, input logic e, input logic g);
    samples_checked++;
    if (g !== e)
    begin
      $display("[FAIL] %s expected %b seen %b", name, e, g);
      fail_count++;
    end
  endtask
  task check_byte(input string name, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e)
    begin
      $display("[FAIL] %s expected %h seen %h", name, e, g);
      fail_count++;
    end
  endtask
  task check_count(input string name, input int e, input int g);
    samples_checked++;
    if (g != e)
    begin
      $display("[FAIL] %s expected %0d seen %0d", name, e, g);
      fail_count++;
    end
  endtask
  // ==========================================
  // Helpers
  function automatic logic [11:0] rnd12();
    int r;
    r = $random(seed);
    return r[11:0];
  endfunction
  function automatic int abits(input logic [7:0] op);
    return (op inside {8'h12, 8'h34, 8'hDC} || ext) ? 32 : 24;
  endfunction
  task cycles(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task wait_prog(input int lim);
    for (k = 0; k < lim && sr1[0] !== 1'b0; k++)
      @(negedge mclk);
    if (sr1[0] !== 1'b0)
    begin
      $display("[FAIL] progress wait expected 0 seen %b", sr1[0]);
      fail_count++;
      conclude();
    end
  endtask
  task cmd(input logic [7:0] op);
    u_sfpe_host.frame(op, 0, 32'h0000_0000, none_q, 1'b0, 0);
    cycles(2);
  endtask
  task automatic prog_start(input logic [7:0] op, input logic [11:0] a,
    input int n, input bit busy);
    logic [7:0] d[$];
    logic [11:0] w;
    int j;
    for (j = 0; j < n; j++)
      d.push_back(rnd12() >> 4);
    u_sfpe_host.frame(op, abits(op), {20'h0_0000, a}, d,
      op inside {8'h32, 8'h38, 8'h34}, 0);
    if (busy && !arr_fail)
      for (j = 0; j < n; j++)
      begin
        w = {a[11:9], a[8:0] + j[8:0]};
        exp_mem[w] = exp_mem[w] & d[j];
      end
    check_bit("progress", busy, sr1[0]);
  endtask
  task automatic prog_end(input logic [11:0] a);
    int j;
    cycles(20);
    wait_prog(8000);
    check_bit("latch", 1'b0, sr1[1]);
    for (j = 0; j < 512; j++)
      check_byte("array", exp_mem[{a[11:9], j[8:0]}],
        mem[{a[11:9], j[8:0]}]);
  endtask
  task automatic prog(input logic [7:0] op, input logic [11:0] a,
    input int n, input bit busy);
    prog_start(op, a, n, busy);
    prog_end(a);
  endtask
  task automatic erase(input logic [7:0] op, input int xb, input int n);
    int e0;
    e0 = erase_seen;
    cmd(8'h06);
    u_sfpe_host.frame(op, op inside {8'h60, 8'hC7} ? 0 : abits(op),
      {20'h0_0000, rnd12()}, none_q, 1'b0, xb);
    if (n > 0)
      check_bit("progress", 1'b1, sr1[0]);
    wait_prog(2000);
    check_count("erases", n, erase_seen - e0);
    check_bit("latch", 1'b0, sr1[1]);
  endtask
  // ==========================================
  // Main sequence
  initial
  begin
    {mclk, rst_b, quad_enable, ext, sector_lock} = 5'h00;
    {bp2, bp1, bp0, err_clear, arr_fail} = 5'h00;
    fail_count = 0;
    samples_checked = 0;
    erase_seen = 0;
    seed = 58;
    for (i = 0; i < 4096; i++)
    begin
      mem[i] = rnd12() >> 2;
      exp_mem[i] = mem[i];
    end
    cycles(10);
    rst_b = 1'b1;
    cycles(3);
    check_byte("status one", 8'h00, sr1);
    check_byte("status two", 8'h00, sr2);
    prog(8'h02, 12'h100, 4, 1'b0);
    cmd(8'h06);
    check_bit("latch", 1'b1, sr1[1]);
    prog(8'h02, 12'h3FE, 4, 1'b1);
    for (i = 0; i < 6; i++)
    begin
      ext = i[0];
      cmd(8'h06);
      prog(i[1] ? 8'h12 : 8'h02, rnd12(), 1 + (rnd12() & 31), 1'b1);
    end
    ext = 1'b0;
    cmd(8'h06);
    prog(8'h02, 12'h600, 512, 1'b1);
    $display("test single program done");
    cmd(8'h06);
    prog(8'h32, 12'h800, 4, 1'b0);
    quad_enable = 1'b1;
    for (i = 0; i < 3; i++)
    begin
      for (k = 0; k < 512; k++)
      begin
        mem[12'hA00 + i * 512 + k] = 8'hFF;
        exp_mem[12'hA00 + i * 512 + k] = 8'hFF;
      end
      ext = i[0];
      cmd(8'h06);
      prog(qops[i], 12'hA07 + i * 512, 1 + i * 3, 1'b1);
    end
    $display("test quad program done");
    arr_fail = 1'b1;
    cmd(8'h06);
    prog(8'h02, 12'h200, 4, 1'b1);
    check_bit("program error", 1'b1, sr1[6]);
    arr_fail = 1'b0;
    err_clear = 1'b1;
    cycles(1);
    err_clear = 1'b0;
    cycles(1);
    check_bit("program error", 1'b0, sr1[6]);
    cmd(8'h06);
    prog_start(8'h02, 12'h400, 40, 1'b1);
    cmd(8'h85);
    wait_prog(2300);
    check_bit("suspended", 1'b1, sr2[0]);
    cmd(8'h8A);
    check_bit("progress", 1'b1, sr1[0]);
    check_bit("suspended", 1'b0, sr2[0]);
    prog_end(12'h400);
    cmd(8'h8A);
    check_bit("progress", 1'b0, sr1[0]);
    cmd(8'h85);
    check_bit("suspended", 1'b0, sr2[0]);
    $display("test suspend done");
    erase(8'hD8, 0, 1);
    ext = 1'b1;
    erase(8'hD8, 0, 1);
    ext = 1'b0;
    erase(8'hDC, 0, 1);
    erase(8'hD8, 1, 0);
    sector_lock = 1'b1;
    erase(8'hD8, 0, 0);
    check_bit("erase error", 1'b1, sr1[5]);
    err_clear = 1'b1;
    cycles(1);
    err_clear = 1'b0;
    erase(8'hC7, 0, 0);
    check_bit("erase error", 1'b0, sr1[5]);
    sector_lock = 1'b0;
    bp0 = 1'b1;
    erase(8'h60, 0, 0);
    check_bit("erase error", 1'b0, sr1[5]);
    bp0 = 1'b0;
    erase(8'h60, 1, 0);
    erase(8'hC7, 0, 8);
    $display("test erase done");
    conclude();
  end
endmodule
`default_nettype wire
